/* File: rtl/power_clock_manager.sv */
/*
 * power manager: master clock selection, processor, peripheral, usb and
 * programmable clock gating, oscillator start-up, frequency meter, pll
 * lock timer, all behind a classic Wishbone slave.
 * assumes slow, main and pll clocks arrive as pins sampled by the core
 * clock, which is much faster than any of them.
 *
 */
`timescale 1ns/1ps
`default_nettype none

module power_clock_manager #(
   parameter int NPER = 32
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [7:0] WB_ADR,
   input wire logic [3:0] WB_SEL,
   input wire logic [31:0] WB_DAT_W,
   output logic [31:0] WB_DAT_R,
   output logic WB_ACK,
   input wire logic SLOW_CLK_IN,
   input wire logic MAIN_CLK_IN,
   input wire logic PLL_CLK_IN,
   input wire logic FAST_IRQ,
   input wire logic NORM_IRQ,
   input wire logic INSTR_DONE,
   output logic MAIN_OSC_EN,
   output pm_pkg::pll_cfg_t PLL_CFG,
   output logic MASTER_CLK,
   output logic CPU_CLK,
   output logic [NPER-1:0] PERIPH_CLK,
   output logic USB_CLK,
   output logic [pm_pkg::PROG_NUM-1:0] PROG_CLK
);
   import pm_pkg::*;

   // ==========================================================
   // byte-lane merge for read-write registers
   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // pin synchronisers: three flops, change counts when 2nd and 3rd agree
   logic [2:0] s1, s2, s3, lvl;
   wire [2:0] pins = {PLL_CLK_IN, MAIN_CLK_IN, SLOW_CLK_IN};
   wire [2:0] agree = ~(s2 ^ s3);
   wire [2:0] chg = agree & (s3 ^ lvl);
   wire slow_rise = chg[0] & s3[0];
   wire main_rise = chg[1] & s3[1];
   wire slow_tick = slow_rise;

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         s1 <= 3'h0;
         s2 <= 3'h0;
         s3 <= 3'h0;
         lvl <= 3'h0;
      end else begin
         s1 <= pins;
         s2 <= s1;
         s3 <= s2;
         lvl <= (agree & s3) | (~agree & lvl);
      end
   end

   // ==========================================================
   // bus decode; ack one cycle after request, write at ack edge
   wire req = WB_CYC & WB_STB;
   wire wr = req & WB_WE & WB_ACK;
   wire [7:0] adr = {WB_ADR[7:2], 2'b00};
   wire wr_sys_en = wr && adr == SYS_EN_OFS;
   wire wr_sys_dis = wr && adr == SYS_DIS_OFS;
   wire wr_per_en = wr && adr == PER_EN_OFS;
   wire wr_per_dis = wr && adr == PER_DIS_OFS;
   wire wr_osc = wr && adr == MAIN_OSC_OFS;
   wire wr_pll = wr && adr == PLL_CFG_OFS;
   wire wr_mck = wr && adr == MCK_CFG_OFS;
   wire prog_hit = adr[7:4] == PROG_CFG_OFS[7:4];
   wire [3:0] wd = WB_DAT_W[SYS_PROG_LSB +: 4];

   // ==========================================================
   // configuration registers
   clk_cfg_t mck_cfg;
   pll_cfg_t pll_cfg;
   logic osc_en;
   logic [7:0] osc_cnt;
   clk_cfg_t prog_cfg [PROG_NUM];
   wire [31:0] mck_img = {27'h0, mck_cfg.clock_divide_select, mck_cfg.clock_source_select};
   wire [31:0] pll_img = {2'h0, pll_cfg.usb_ratio, 1'b0,
      pll_cfg.feedback, 2'h0, pll_cfg.lock_cnt, pll_cfg.in_div};
   wire [31:0] osc_img = {16'h0, osc_cnt, 7'h0, osc_en};
   wire [31:0] mck_new = merge(mck_img, WB_DAT_W, WB_SEL);
   wire [31:0] pll_new = merge(pll_img, WB_DAT_W, WB_SEL);
   wire [31:0] osc_new = merge(osc_img, WB_DAT_W, WB_SEL);

   // master config write clears ready via divider restart
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         mck_cfg <= CLK_CFG_RST;
      end else if (wr_mck) begin
         mck_cfg.clock_source_select <= mck_new[CSS_LSB +: 2];
         mck_cfg.clock_divide_select <= mck_new[CLOCK_DIVIDE_SELECT_LSB +: 3];
      end
   end

   // pll and oscillator setting registers
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         pll_cfg <= PLL_CFG_RST;
         osc_en <= 1'b0;
         osc_cnt <= OSC_CNT_RST;
      end else begin
         if (wr_pll) begin
            pll_cfg.in_div <= pll_new[PLL_DIV_LSB +: 8];
            pll_cfg.lock_cnt <= pll_new[PLL_CNT_LSB +: 6];
            pll_cfg.feedback <= pll_new[PLL_MUL_LSB +: 11];
            pll_cfg.usb_ratio <= pll_new[PLL_USB_LSB +: 2];
         end
         if (wr_osc) begin
            osc_en <= osc_new[OSC_EN_BIT];
            osc_cnt <= osc_new[OSC_CNT_LSB +: 8];
         end
      end
   end

   // ==========================================================
   // system and peripheral clock gates; set wins over clear
   logic cpu_on, stop_pend, usb_on;
   logic [PROG_NUM-1:0] prog_on;
   logic [NPER-1:0] per_on;
   wire irq_wake = FAST_IRQ | NORM_IRQ;
   wire cpu_stop_req = wr_sys_dis & WB_DAT_W[SYS_CPU_BIT];

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         cpu_on <= 1'b1;
         stop_pend <= 1'b0;
      end else if (irq_wake) begin
         cpu_on <= 1'b1;
         stop_pend <= 1'b0;
      end else if (cpu_stop_req || stop_pend) begin
         stop_pend <= ~INSTR_DONE;
         cpu_on <= cpu_on & ~INSTR_DONE;
      end
   end

   // usb, programmable and peripheral enables
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         usb_on <= 1'b0;
         prog_on <= '0;
         per_on <= '0;
      end else begin
         usb_on <= (usb_on & ~(wr_sys_dis & WB_DAT_W[SYS_USB_BIT]))
            | (wr_sys_en & WB_DAT_W[SYS_USB_BIT]);
         prog_on <= (prog_on & ~({4{wr_sys_dis}} & wd))
            | ({4{wr_sys_en}} & wd);
         per_on <= (per_on & ~({NPER{wr_per_dis}} & WB_DAT_W[NPER-1:0]))
            | ({NPER{wr_per_en}} & WB_DAT_W[NPER-1:0]);
      end
   end

   // ==========================================================
   // main oscillator start-up timer on slow clock / 8
   logic osc_stable;
   logic [7:0] osc_left;
   logic [2:0] osc_pre;

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         osc_stable <= 1'b0;
         osc_left <= 8'h00;
         osc_pre <= 3'h0;
      end else if (wr_osc) begin
         osc_stable <= 1'b0;
         osc_left <= osc_new[OSC_CNT_LSB +: 8];
         osc_pre <= 3'h0;
      end else if (!osc_en) begin
         osc_stable <= 1'b0;
      end else if (!osc_stable && slow_tick) begin
         osc_pre <= osc_pre + 3'h1;
         if (osc_pre == OSC_TICK_DIV) begin
            // flag rises on the tick that brings the count to zero
            if (osc_left <= 8'h01) begin
               osc_stable <= 1'b1;
            end
            if (osc_left != 8'h00) begin
               osc_left <= osc_left - 8'h01;
            end
         end
      end
   end

   // ==========================================================
   // main frequency meter over sixteen slow periods
   typedef enum {F_IDLE, F_ARM, F_COUNT, F_DONE} freq_st_t;
   freq_st_t fst;
   logic [15:0] freq_cnt;
   logic [4:0] periods;

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || !osc_stable) begin
         fst <= F_IDLE;
         freq_cnt <= 16'h0000;
         periods <= 5'h00;
      end else begin
         case (fst)
            F_IDLE: fst <= F_ARM;
            F_ARM: begin
               if (slow_rise) begin
                  fst <= F_COUNT;
               end
            end
            F_COUNT: begin
               if (main_rise) begin
                  freq_cnt <= freq_cnt + 16'h0001;
               end
               // window closes after sixteen full slow periods
               if (slow_rise) begin
                  periods <= periods + 5'h01;
                  if (periods + 5'h01 == FREQ_WINDOW) begin
                     fst <= F_DONE;
                  end
               end
            end
            F_DONE: fst <= F_DONE;
            default: fst <= F_IDLE;
         endcase
      end
   end
   wire freq_rdy = fst == F_DONE;

   // ==========================================================
   // pll lock timer on slow clock
   logic lock;
   logic [5:0] lock_left;
   wire pll_off = pll_cfg.in_div == 8'h00 ||
                  pll_cfg.feedback == 11'h000;

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         lock <= 1'b0;
         lock_left <= PLL_CFG_RST.lock_cnt;
      end else if (wr_pll) begin
         lock <= 1'b0;
         lock_left <= pll_new[PLL_CNT_LSB +: 6];
      end else if (!lock && !pll_off && slow_tick) begin
         if (lock_left <= 6'h01) begin
            lock <= 1'b1;
         end
         if (lock_left != 6'h00) begin
            lock_left <= lock_left - 6'h01;
         end
      end
   end

   // ==========================================================
   // master clock: fallback to main while pll unlocked
   wire pll_fallback = mck_cfg.clock_source_select == CSS_PLL && !lock;
   wire css_t mck_css = pll_fallback ? CSS_MAIN : mck_cfg.clock_source_select;
   logic fallback_q;
   logic mck_out, mck_match, usb_out, usb_match;
   wire mck_restart = wr_mck || (pll_fallback != fallback_q);
   wire mck_rdy = mck_match & ~pll_fallback
      & ~mck_restart;

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         fallback_q <= 1'b0;
      end else begin
         fallback_q <= pll_fallback;
      end
   end

   clock_select_divider u_mck (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .src_chg(chg),
      .sel(mck_css),
      .clock_divide_select(mck_cfg.clock_divide_select),
      .restart(mck_restart),
      .clk_out(mck_out),
      .match(mck_match)
   );

   // usb clock is the pll output divided by 1, 2, 4 or 8
   clock_select_divider u_usb (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .src_chg(chg),
      .sel(CSS_PLL),
      .clock_divide_select({1'b0, pll_cfg.usb_ratio}),
      .restart(wr_pll),
      .clk_out(usb_out),
      .match(usb_match)
   );

   // ==========================================================
   // programmable clock outputs
   logic [PROG_NUM-1:0] prog_out, prog_match;
   genvar g;
   generate
      for (g = 0; g < PROG_NUM; g++) begin : g_prog
         wire wr_prog = wr && prog_hit && adr[3:2] == 2'(g);
         wire [31:0] img = {27'h0, prog_cfg[g].clock_divide_select, prog_cfg[g].clock_source_select};
         wire [31:0] nv = merge(img, WB_DAT_W, WB_SEL);

         // setting register per output
         always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
               prog_cfg[g] <= CLK_CFG_RST;
            end else if (wr_prog) begin
               prog_cfg[g].clock_source_select <= nv[CSS_LSB +: 2];
               prog_cfg[g].clock_divide_select <= nv[CLOCK_DIVIDE_SELECT_LSB +: 3];
            end
         end

         clock_select_divider u_prog (
            .clk(CORE_CLK),
            .rst(SYS_RST),
            .src_chg(chg),
            .sel(prog_cfg[g].clock_source_select),
            .clock_divide_select(prog_cfg[g].clock_divide_select),
            .restart(wr_prog),
            .clk_out(prog_out[g]),
            .match(prog_match[g])
         );
      end
   endgenerate

   // ==========================================================
   // clock outputs, registered; all but MASTER_CLK gated
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         MASTER_CLK <= 1'b0;
         CPU_CLK <= 1'b0;
         PERIPH_CLK <= '0;
         USB_CLK <= 1'b0;
         PROG_CLK <= '0;
      end else begin
         MASTER_CLK <= mck_out;
         CPU_CLK <= mck_out & cpu_on;
         PERIPH_CLK <= {NPER{mck_out}} & per_on;
         USB_CLK <= usb_out & usb_on & lock;
         PROG_CLK <= prog_out & prog_on;
      end
   end
   assign MAIN_OSC_EN = osc_en;
   assign PLL_CFG = pll_cfg;

   // ==========================================================
   // read data selection
   wire [31:0] sys_stat = {20'h0, prog_on, usb_on, 6'h0, cpu_on};
   wire [31:0] per_stat = 32'(per_on);
   wire [31:0] freq_img = {15'h0, freq_rdy, freq_cnt};
   wire [31:0] pm_stat = {20'h0, prog_match & prog_on, 4'h0,
      mck_rdy, lock, 1'b0, osc_stable};
   wire [31:0] prog_img = {27'h0, prog_cfg[adr[3:2]].clock_divide_select,
      prog_cfg[adr[3:2]].clock_source_select};
   wire [31:0] rd_word =
      adr == SYS_STAT_OFS ? sys_stat :
      adr == PER_STAT_OFS ? per_stat :
      adr == MAIN_OSC_OFS ? osc_img :
      adr == MAIN_FREQ_OFS ? freq_img :
      adr == PLL_CFG_OFS ? pll_img :
      adr == MCK_CFG_OFS ? mck_img :
      prog_hit ? prog_img :
      adr == PM_STAT_OFS ? pm_stat : 32'h0000_0000;

   // bus answer: ack and data registered, one cycle per request
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         WB_ACK <= 1'b0;
         WB_DAT_R <= 32'h0000_0000;
      end else begin
         WB_ACK <= req & ~WB_ACK;
         WB_DAT_R <= (req & ~WB_ACK & ~WB_WE) ? rd_word : 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

/* File: rtl/pm_pkg.sv */
/*
 * power manager shared definitions: register offsets, field positions,
 * reset values, carrier structs and timing counts.
 * assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package pm_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] SYS_EN_OFS = 8'h00;
   localparam logic [7:0] SYS_DIS_OFS = 8'h04;
   localparam logic [7:0] SYS_STAT_OFS = 8'h08;
   localparam logic [7:0] PER_EN_OFS = 8'h10;
   localparam logic [7:0] PER_DIS_OFS = 8'h14;
   localparam logic [7:0] PER_STAT_OFS = 8'h18;
   localparam logic [7:0] MAIN_OSC_OFS = 8'h20;
   localparam logic [7:0] MAIN_FREQ_OFS = 8'h24;
   localparam logic [7:0] PLL_CFG_OFS = 8'h2C;
   localparam logic [7:0] MCK_CFG_OFS = 8'h30;
   localparam logic [7:0] PROG_CFG_OFS = 8'h40;
   localparam logic [7:0] PM_STAT_OFS = 8'h68;

   // ==========================================================
   // field positions
   localparam int SYS_CPU_BIT = 0;
   localparam int SYS_USB_BIT = 7;
   localparam int SYS_PROG_LSB = 8;
   localparam int CSS_LSB = 0;
   localparam int CLOCK_DIVIDE_SELECT_LSB = 2;
   localparam int OSC_EN_BIT = 0;
   localparam int OSC_CNT_LSB = 8;
   localparam int FREQ_RDY_BIT = 16;
   localparam int PLL_DIV_LSB = 0;
   localparam int PLL_CNT_LSB = 8;
   localparam int PLL_MUL_LSB = 16;
   localparam int PLL_USB_LSB = 28;
   localparam int ST_OSC_BIT = 0;
   localparam int ST_LOCK_BIT = 2;
   localparam int ST_MCK_BIT = 3;
   localparam int ST_PROG_LSB = 8;

   // ==========================================================
   // field types and encodings
   typedef logic [1:0] css_t;
   typedef logic [2:0] clock_divide_select_t;
   localparam css_t CSS_SLOW = 2'h0;
   localparam css_t CSS_MAIN = 2'h1;
   localparam css_t CSS_PLL = 2'h3;
   localparam clock_divide_select_t CLOCK_DIVIDE_SELECT_MAX = 3'h6;

   typedef struct packed {
      css_t clock_source_select;
      clock_divide_select_t clock_divide_select;
   } clk_cfg_t;

   typedef struct packed {
      logic [1:0] usb_ratio;
      logic [10:0] feedback;
      logic [5:0] lock_cnt;
      logic [7:0] in_div;
   } pll_cfg_t;

   // ==========================================================
   // reset values and timing counts
   localparam clk_cfg_t CLK_CFG_RST = '{clock_source_select: CSS_SLOW, clock_divide_select: 3'h0};
   localparam pll_cfg_t PLL_CFG_RST = '{usb_ratio: 2'h0,
      feedback: 11'h000, lock_cnt: 6'h3F, in_div: 8'h00};
   localparam logic [7:0] OSC_CNT_RST = 8'h00;
   localparam logic [2:0] OSC_TICK_DIV = 3'h7;
   localparam logic [4:0] FREQ_WINDOW = 5'h10;
   localparam int PROG_NUM = 4;

endpackage

/* File: rtl/clock_select_divider.sv */
/*
 * source selector and power-of-two prescaler for one derived clock.
 * assumes one-cycle change pulses of each source, already synchronised
 * to the core clock; the output toggles every 2^clock_divide_select source changes, with the select clamped to 6.
 */
`timescale 1ns/1ps
`default_nettype none

module clock_select_divider (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] src_chg,
   input wire pm_pkg::css_t sel,
   input wire pm_pkg::clock_divide_select_t clock_divide_select,
   input wire logic restart,
   output logic clk_out,
   output logic match
);
   import pm_pkg::*;

   // ==========================================================
   // source pick and terminal count
   logic [5:0] cnt;
   wire tick = (sel == CSS_MAIN) ? src_chg[1] :
               (sel == CSS_PLL) ? src_chg[2] : src_chg[0];
   wire clock_divide_select_t clock_divide_select_c = (clock_divide_select > CLOCK_DIVIDE_SELECT_MAX) ? CLOCK_DIVIDE_SELECT_MAX : clock_divide_select;
   wire [5:0] limit = 6'((7'h01 << clock_divide_select_c) - 7'h01);

   // ==========================================================
   // counter; match rises after one full period of new setting
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         cnt <= 6'h00;
         clk_out <= 1'b0;
         match <= 1'b0;
      end else if (tick) begin
         if (cnt == limit) begin
            cnt <= 6'h00;
            clk_out <= ~clk_out;
            match <= match | clk_out;
         end else begin
            cnt <= cnt + 6'h01;
         end
      end
   end

endmodule

`default_nettype wire

/* File: tb/power_clock_manager_sva.sv */
/* assertion checker for the power manager top-level ports.
   assumes it is bound into every power_clock_manager instance. */
`timescale 1ns/1ps
`default_nettype none

module power_clock_manager_sva #(
   parameter int NPER = 32
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [7:0] WB_ADR,
   input wire logic [3:0] WB_SEL,
   input wire logic [31:0] WB_DAT_W,
   input wire logic [31:0] WB_DAT_R,
   input wire logic WB_ACK,
   input wire logic MAIN_OSC_EN,
   input wire pm_pkg::pll_cfg_t PLL_CFG,
   input wire logic [NPER-1:0] PERIPH_CLK,
   input wire logic USB_CLK
);
   import pm_pkg::*;
   // ==========================================================
   // write decode seen at the acknowledging edge
   wire logic req = WB_CYC && WB_STB;
   wire logic wr = WB_ACK && WB_WE;
   wire logic pll_wr = wr && WB_ADR == PLL_CFG_OFS && WB_SEL == 4'hF;
   wire logic osc_wr = wr && WB_ADR == MAIN_OSC_OFS && WB_SEL[0];
   wire logic dis_wr = wr && WB_ADR == PER_DIS_OFS;
   wire logic [26:0] pll_new = {WB_DAT_W[29:28], WB_DAT_W[26:16],
      WB_DAT_W[13:8], WB_DAT_W[7:0]};

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   // ==========================================================
   // bus handshake and register side effects
   a_ack_single: assert property (WB_ACK |=> !WB_ACK)
      else $error("ack longer than one cycle");
   a_ack_answers: assert property (req && !WB_ACK |=> WB_ACK)
      else $error("request not answered next cycle");
   a_ack_needs_req: assert property (!req |=> !WB_ACK)
      else $error("ack without request");
   a_rdata_quiet: assert property (!WB_ACK |-> WB_DAT_R == 32'h0)
      else $error("read data outside ack");
   a_hole_zero: assert property (WB_ACK && !WB_WE && WB_ADR == 8'h0C
      |-> WB_DAT_R == 32'h0)
      else $error("unmapped read not zero");
   a_pll_loaded: assert property (pll_wr |=>
      PLL_CFG == $past(pll_new))
      else $error("pll setting not taken");
   a_osc_loaded: assert property (osc_wr |=>
      MAIN_OSC_EN == $past(WB_DAT_W[0]))
      else $error("oscillator enable not taken");
   a_periph_stop: assert property (dis_wr |=> ##1
      (PERIPH_CLK & $past(WB_DAT_W[NPER-1:0], 2)) == '0)
      else $error("peripheral clock runs after disable");
   a_usb_needs_pll: assert property (USB_CLK |->
      $past(PLL_CFG.in_div) != 8'h00 &&
      $past(PLL_CFG.feedback) != 11'h000)
      else $error("usb clock with pll off");

   c_pll_write: cover property (pll_wr);
   c_periph_off: cover property (dis_wr);
   c_usb_runs: cover property ($rose(USB_CLK));
endmodule

bind power_clock_manager power_clock_manager_sva #(.NPER(NPER)) u_sva (
   .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .WB_CYC(WB_CYC),
   .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL),
   .WB_DAT_W(WB_DAT_W), .WB_DAT_R(WB_DAT_R), .WB_ACK(WB_ACK),
   .MAIN_OSC_EN(MAIN_OSC_EN), .PLL_CFG(PLL_CFG),
   .PERIPH_CLK(PERIPH_CLK), .USB_CLK(USB_CLK)
);
`default_nettype wire

/* File: tb/power_clock_manager_tb.sv */
/* self-checking bench for the power manager over Wishbone.
   assumes source pins far slower than the 10 MHz core clock. */
`timescale 1ns/1ps
`default_nettype none

module power_clock_manager_tb;
   import pm_pkg::*;
   logic CORE_CLK, SYS_RST, cyc, stb, we, ack, slow, mainc, pllc;
   logic fiq, nirq, idone, osc_en, master_clock, cpu, usb;
   logic [7:0] adr;
   logic [31:0] dw, dr, q;
   logic [31:0] per;
   logic [3:0] prog;
   logic [4:0] seen;
   pll_cfg_t pll;
   int tick, error_cnt, checks;

   power_clock_manager DUT (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
      .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr),
      .WB_SEL(4'hF), .WB_DAT_W(dw), .WB_DAT_R(dr), .WB_ACK(ack),
      .SLOW_CLK_IN(slow), .MAIN_CLK_IN(mainc), .PLL_CLK_IN(pllc),
      .FAST_IRQ(fiq), .NORM_IRQ(nirq), .INSTR_DONE(idone),
      .MAIN_OSC_EN(osc_en), .PLL_CFG(pll), .MASTER_CLK(master_clock),
      .CPU_CLK(cpu), .PERIPH_CLK(per), .USB_CLK(usb), .PROG_CLK(prog));

   // ==========================================================
   // core clock and source pins: slow 20, main 8, pll 6 cycles
   initial begin
      CORE_CLK = 1'b0;
      forever #50 CORE_CLK = ~CORE_CLK;
   end
   always @(posedge CORE_CLK) begin
      tick <= tick + 1;
      if (tick % 10 == 0) slow <= ~slow;
      if (tick % 4 == 0) mainc <= ~mainc;
      if (tick % 3 == 0) pllc <= ~pllc;
   end

   // ==========================================================
   // bus and compare tasks
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge CORE_CLK);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      // ends on ack; only the watchdog ends a wait that never gets one
      do begin
         @(posedge CORE_CLK);
      end while (ack !== 1'b1);
      q = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(q, exp);
   endtask

   task automatic poll(input logic [7:0] a, input int b);
      int i;
      i = 0;
      do begin
         wb(1'b0, a, 32'h0);
         i++;
      end while (q[b] !== 1'b1 && i < 400);
      check({31'h0, q[b]}, 32'h1);
   endtask

   // records whether master, prog0, usb, cpu, periph8 were seen high;
   // first edge skipped, the outputs are registered one cycle late
   task automatic watch(input int n);
      seen = 5'h00;
      @(posedge CORE_CLK);
      repeat (n) begin
         @(posedge CORE_CLK);
         seen = seen | {master_clock, prog[0], usb, cpu, per[8]};
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ==========================================================
   // watchdog
   initial begin
      repeat (40000) @(posedge CORE_CLK);
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end

   // ==========================================================
   // test sequence
   initial begin
      {SYS_RST, cyc, stb, we, slow, mainc, pllc} = 7'h40;
      {fiq, nirq, idone, adr, dw, tick} = '0;
      repeat (16) @(posedge CORE_CLK);
      SYS_RST <= 1'b0;
      rd_chk(SYS_STAT_OFS, 32'h1);
      rd_chk(PER_STAT_OFS, 32'h0);
      rd_chk(MAIN_OSC_OFS, 32'h0);
      rd_chk(MAIN_FREQ_OFS, 32'h0);
      rd_chk(PLL_CFG_OFS, 32'h3F00);
      rd_chk(MCK_CFG_OFS, 32'h0);
      rd_chk(PROG_CFG_OFS, 32'h0);
      rd_chk(8'h0C, 32'h0);
      $display("test reset values done");
      wb(1'b1, PER_EN_OFS, 32'h110);
      rd_chk(PER_STAT_OFS, 32'h110);
      watch(80);
      check({31'h0, seen[0]}, 32'h1);
      check({31'h0, seen[4]}, 32'h1);
      wb(1'b1, PER_DIS_OFS, 32'h10);
      rd_chk(PER_STAT_OFS, 32'h100);
      wb(1'b1, PER_DIS_OFS, 32'h100);
      watch(80);
      check({31'h0, seen[0]}, 32'h0);
      $display("test peripheral gating done");
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, SYS_DIS_OFS, 32'h1);
         watch(60);
         check({31'h0, seen[1]}, 32'h1);
         idone <= 1'b1;
         @(posedge CORE_CLK);
         idone <= 1'b0;
         rd_chk(SYS_STAT_OFS, 32'h0);
         watch(60);
         check({31'h0, seen[1]}, 32'h0);
         if (k == 0) fiq <= 1'b1;
         else nirq <= 1'b1;
         @(posedge CORE_CLK);
         {fiq, nirq} <= 2'h0;
         rd_chk(SYS_STAT_OFS, 32'h1);
      end
      $display("test processor idle done");
      wb(1'b1, MAIN_OSC_OFS, 32'h201);
      repeat (250) @(posedge CORE_CLK);
      check({31'h0, osc_en}, 32'h1);
      wb(1'b0, PM_STAT_OFS, 32'h0);
      check({31'h0, q[ST_OSC_BIT]}, 32'h0);
      poll(PM_STAT_OFS, ST_OSC_BIT);
      poll(MAIN_FREQ_OFS, FREQ_RDY_BIT);
      check({31'h0, q[15:0] >= 16'h27 && q[15:0] <= 16'h29}, 32'h1);
      $display("test oscillator done");
      wb(1'b1, PLL_CFG_OFS, 32'h40201);
      @(posedge CORE_CLK);
      check({5'h0, pll}, 32'h00010201);
      wb(1'b0, PM_STAT_OFS, 32'h0);
      check({31'h0, q[ST_LOCK_BIT]}, 32'h0);
      poll(PM_STAT_OFS, ST_LOCK_BIT);
      wb(1'b1, PROG_CFG_OFS, 32'h1);
      wb(1'b1, SYS_EN_OFS, 32'h180);
      rd_chk(SYS_STAT_OFS, 32'h181);
      poll(PM_STAT_OFS, ST_PROG_LSB);
      watch(60);
      check({30'h0, seen[3:2]}, 32'h3);
      wb(1'b1, SYS_DIS_OFS, 32'h180);
      rd_chk(SYS_STAT_OFS, 32'h1);
      watch(60);
      check({30'h0, seen[3:2]}, 32'h0);
      $display("test pll usb and outputs done");
      wb(1'b1, MCK_CFG_OFS, 32'h1);
      wb(1'b0, PM_STAT_OFS, 32'h0);
      check({31'h0, q[ST_MCK_BIT]}, 32'h0);
      poll(PM_STAT_OFS, ST_MCK_BIT);
      wb(1'b1, MCK_CFG_OFS, 32'h5);
      poll(PM_STAT_OFS, ST_MCK_BIT);
      wb(1'b1, MCK_CFG_OFS, 32'h7);
      poll(PM_STAT_OFS, ST_MCK_BIT);
      rd_chk(MCK_CFG_OFS, 32'h7);
      wb(1'b1, PLL_CFG_OFS, 32'h40201);
      wb(1'b0, PM_STAT_OFS, 32'h0);
      check({30'h0, q[ST_MCK_BIT], q[ST_LOCK_BIT]}, 32'h0);
      poll(PM_STAT_OFS, ST_MCK_BIT);
      $display("test master clock done");
      give_verdict();
   end
endmodule
`default_nettype wire
